// File: verilog/krsc_control.sv
/*
  Sequencer control register of the backplane link PHY, lane 0 of the four-lane build, with the event logic
  that the register steers: restart, reconfiguration start, timer enables and training failure handling.
  Assumes the management port, the sequencer and the negotiation and training engines all run on sys_clk;
  read data is answered one cycle after the read strobe, writes take effect at the strobe edge.
*/
module krsc_control (
  // Clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        rst_n,
  // Management slave port
  input  wire logic [krsc_pkg::ADDR_W-1:0] mgmtAddr,
  input  wire logic                        mgmtRead,
  input  wire logic                        mgmtWrite,
  input  wire logic [krsc_pkg::DATA_W-1:0] mgmtWriteData,
  output logic      [krsc_pkg::DATA_W-1:0] mgmtReadData,
  output logic                             mgmtReadValid,
  // Engine status, lane 0
  input  wire logic                        negotiationEnabled,
  input  wire logic                        trainingEnabled,
  input  wire logic                        trainingFailIn,
  input  wire logic                        trainingRunDone,
  input  wire logic [krsc_pkg::ERR_W-1:0]  trainingLastError,
  // Sequencer controls, lane 0
  output logic                             seqRestart,
  output logic                             reconfigStart,
  output logic                             reconfigCalibrate,
  output logic [3:0]                       activeProtocol,
  output logic                             negotiationTimerOn,
  output logic                             linkFailTimerOn,
  output logic                             negotiationRestart,
  output logic                             trainingRestart,
  output logic                             enterDataMode
);

  ////////////////////////////////////////////////////////////////////////////////////////////////////////////
  // Address decode

  // One address space holds every register; only the control word is implemented in this block.
  function automatic logic isCtrlWord(input logic [krsc_pkg::ADDR_W-1:0] addr);
    isCtrlWord = (addr == krsc_pkg::CTRL_WORD); // R14 R16
  endfunction

  logic ctrlWrite;
  logic ctrlRead;
  logic restartWrite;

  assign ctrlWrite    = mgmtWrite && isCtrlWord(mgmtAddr);
  assign ctrlRead     = mgmtRead && isCtrlWord(mgmtAddr);
  assign restartWrite = ctrlWrite && mgmtWriteData[krsc_pkg::BIT_RESTART]; // R1

  ////////////////////////////////////////////////////////////////////////////////////////////////////////////
  // Control word storage

  logic [krsc_pkg::STORED_MSB:0] ctrl_q;
  logic [krsc_pkg::STORED_MSB:0] ctrl_d;

  // The restart position is never stored, so it always reads zero and needs no clearing by software.
  assign ctrl_d = ctrlWrite ? {mgmtWriteData[krsc_pkg::STORED_MSB:krsc_pkg::BIT_RESTART + 1], 1'b0}
                            : ctrl_q; // R2

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl_q <= krsc_pkg::CTRL_RESET; // R12
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  logic timerAnOff;
  logic timerLfOff;
  logic errorFailsRun;
  logic calibrateOn;
  logic failToData;

  assign timerAnOff    = ctrl_q[krsc_pkg::BIT_AN_TMR];
  assign timerLfOff    = ctrl_q[krsc_pkg::BIT_LF_TMR];
  assign errorFailsRun = ctrl_q[krsc_pkg::BIT_ERR_FAIL];
  assign calibrateOn   = ctrl_q[krsc_pkg::BIT_CALIB];
  assign failToData    = ctrl_q[krsc_pkg::BIT_FAIL_ACT];

  // With the negotiation timer off a stuck exchange is left for software to resolve.
  assign negotiationTimerOn = !timerAnOff; // R3 R4
  assign linkFailTimerOn    = !timerLfOff; // R5

  ////////////////////////////////////////////////////////////////////////////////////////////////////////////
  // Restart and override capture

  logic       restartPulse;
  logic [3:0] activeOverride;

  krsc_restart_pulse uRestart (
    .sys_clk          (sys_clk),
    .rst_n            (rst_n),
    .restartWrite     (restartWrite),
    .overrideIn       (mgmtWriteData[krsc_pkg::OVR_MSB:krsc_pkg::OVR_LSB]),
    .restartPulse_q   (restartPulse),
    .activeOverride_q (activeOverride)
  );

  // The override field stored in the word is for read-back; the sequencer sees only the captured copy.
  assign seqRestart     = restartPulse; // R1
  assign activeProtocol = activeOverride; // R7 R8

  ////////////////////////////////////////////////////////////////////////////////////////////////////////////
  // Training failure judgement and the events that follow

  logic errorFailure;
  logic trainingFailed;

  // A finished run with residual error counts as failed only when software asks for it.
  assign errorFailure   = trainingRunDone && errorFailsRun && (trainingLastError != '0); // R6
  assign trainingFailed = trainingFailIn || errorFailure;

  logic reconfigStart_d;
  logic reconfigCalibrate_d;
  logic negotiationRestart_d;
  logic trainingRestart_d;
  logic enterDataMode_d;

  assign reconfigStart_d     = restartPulse; // R1
  assign reconfigCalibrate_d = restartPulse && calibrateOn; // R9
  // A restart wakes only the engines that are enabled; a failure follows the chosen response.
  assign negotiationRestart_d = (restartPulse && negotiationEnabled)
                             || (trainingFailed && !failToData && negotiationEnabled); // R1 R10 R17
  assign trainingRestart_d    = (restartPulse && trainingEnabled)
                             || (trainingFailed && !failToData && !negotiationEnabled); // R1 R11
  assign enterDataMode_d      = trainingFailed && failToData; // R10 R15

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      reconfigStart      <= 1'b0;
      reconfigCalibrate  <= 1'b0;
      negotiationRestart <= 1'b0;
      trainingRestart    <= 1'b0;
      enterDataMode      <= 1'b0;
    end else begin
      reconfigStart      <= reconfigStart_d;
      reconfigCalibrate  <= reconfigCalibrate_d;
      negotiationRestart <= negotiationRestart_d;
      trainingRestart    <= trainingRestart_d;
      enterDataMode      <= enterDataMode_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////////////////
  // Read path

  logic [krsc_pkg::DATA_W-1:0] readWord;
  logic [krsc_pkg::DATA_W-1:0] mgmtReadData_d;

  assign readWord       = {{(krsc_pkg::DATA_W - krsc_pkg::STORED_MSB - 1){1'b0}}, ctrl_q};
  // Other addresses inside or outside the PHY window answer zero rather than stalling the port.
  assign mgmtReadData_d = ctrlRead ? readWord : krsc_pkg::READ_ZERO; // R16

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      mgmtReadData  <= krsc_pkg::READ_ZERO;
      mgmtReadValid <= 1'b0;
    end else begin
      mgmtReadData  <= mgmtReadData_d;
      mgmtReadValid <= mgmtRead;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_restart_chain: assert property (restartWrite |=> seqRestart ##1 reconfigStart) // R1
    else $error("restart write did not reach sequencer and reconfiguration");
  a_restart_an: assert property (restartWrite ##1 negotiationEnabled |=> negotiationRestart) // R1
    else $error("restart did not restart enabled negotiation");
  a_restart_reads_zero: assert property (mgmtReadValid |-> !mgmtReadData[krsc_pkg::BIT_RESTART]) // R2
    else $error("restart bit read back as one");
  a_an_timer_bit: assert property (ctrlWrite |=> // R3
      negotiationTimerOn == !$past(mgmtWriteData[krsc_pkg::BIT_AN_TMR]))
    else $error("negotiation timer enable does not follow bit 1");
  a_lf_timer_bit: assert property (ctrlWrite |=> linkFailTimerOn == !$past(mgmtWriteData[krsc_pkg::BIT_LF_TMR])) // R5
    else $error("link-fail timer enable does not follow bit 2");
  a_error_fail: assert property (errorFailure && failToData |=> enterDataMode) // R6
    else $error("non-zero training error was not treated as failure");
  a_override_effect: assert property (restartWrite |=> // R7
      activeProtocol == $past(mgmtWriteData[krsc_pkg::OVR_MSB:krsc_pkg::OVR_LSB]))
    else $error("protocol override not captured at restart");
  a_override_waits: assert property (ctrlWrite && !restartWrite |=> $stable(activeProtocol)) // R8
    else $error("override changed without a restart");
  a_calib_gate: assert property (reconfigCalibrate |-> reconfigStart && $past(calibrateOn)) // R9
    else $error("calibration requested outside a calibrated reconfiguration");
  a_fail_data: assert property (trainingFailed && failToData && !restartPulse // R10
      |=> enterDataMode && !negotiationRestart && !trainingRestart)
    else $error("failure with data response restarted an engine");
  a_fail_an: assert property (trainingFailed && !failToData && negotiationEnabled // R10
      |=> negotiationRestart && !enterDataMode)
    else $error("failure did not restart negotiation");
  a_fail_lt: assert property (trainingFailed && !failToData && !negotiationEnabled // R11
      |=> trainingRestart && !enterDataMode)
    else $error("failure did not restart training");
  a_reset_zero: assert property ($rose(rst_n) |-> ctrl_q == krsc_pkg::CTRL_RESET && activeProtocol == '0) // R12
    else $error("control word not zero after reset");
  a_read_answer: assert property (ctrlRead |=> mgmtReadValid && mgmtReadData == $past(readWord)) // R14
    else $error("control word read answered wrongly");
  a_unmapped_zero: assert property (mgmtRead && !isCtrlWord(mgmtAddr) |=> mgmtReadData == '0) // R16
    else $error("unmapped read returned data");

  // Reconfiguration, calibration, data-mode and read-answer pulses must have their cause one cycle earlier, so a stuck or stray pulse is caught too.
  a_restart_lt: assert property (restartWrite ##1 trainingEnabled |=> trainingRestart) // R1
    else $error("restart did not restart enabled training");
  a_start_source: assert property (reconfigStart |-> $past(seqRestart)) // R1
    else $error("reconfiguration started without a sequencer restart");
  a_calib_follows: assert property (reconfigStart |-> reconfigCalibrate == $past(calibrateOn)) // R9
    else $error("calibration step does not follow bit 8");
  a_data_source: assert property (enterDataMode |-> $past(trainingFailed) && $past(failToData)) // R10
    else $error("data mode entered without a training failure");
  a_reset_quiet: assert property ($rose(rst_n) |-> !seqRestart && !reconfigStart && !enterDataMode // R12
      && !negotiationRestart && !trainingRestart && mgmtReadData == '0)
    else $error("event outputs not quiet after reset");
  a_read_source: assert property (mgmtReadValid |-> $past(mgmtRead)) // R16
    else $error("read answer without a read strobe");
  a_timers_hold: assert property (!ctrlWrite |=> // R3 R5
      $stable(negotiationTimerOn) && $stable(linkFailTimerOn))
    else $error("timer enable changed without a register write");

endmodule

// File: pkg/krsc_pkg.sv
/*
  Constants for the link sequencer control register: where it sits, its fields, their reset values and the
  protocol codes.
  Assumes a word-addressed management port with 32-bit data on the single management clock.
*/
// Contract
// R1: Writing one to restart resets the sequencer, starts reconfiguration, restarts enabled AN/LT.
// R2: The restart bit clears itself after triggering; it always reads back zero.
// R3: Bit 1 set switches the negotiation timer off; clear lets it run.
// R4: Software handles stuck negotiation when the timer is off and partner lacks support.
// R5: Bit 2 set disables the link-fail timer; clear enables it.
// R6: Bit 3 set fails a training run whose last error measurement is non-zero.
// R7: Bits 7 to 4 select the protocol override; other codes are undefined.
// R8: A new override takes effect only at the next restart write.
// R9: Bit 8 set adds the calibration step to reconfiguration; clear skips it.
// R10: Bit 12 set sends training failure to data mode; clear restarts enabled negotiation.
// R11: Bit 12 clear with negotiation disabled makes training failure restart training.
// R12: Every field resets to zero unless its description says otherwise.
// R13: Software must not write reserved or undefined register addresses.
// R14: Four-lane registers sit at 0x4B0 to 0x4FF, displaced 0x400 from single-lane.
// R15: In four-lane builds, training and FEC controls act on lane 0 only.
// R16: All registers share one address space behind the management slave port.
// R17: After changing the FEC request bit, software sets restart to renegotiate.
package krsc_pkg;

  localparam int unsigned ADDR_W = 11;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ERR_W  = 8;

  // Four-lane map: single-lane offset plus the lane displacement.
  localparam logic [10:0] SINGLE_CTRL_WORD = 11'h0b0;
  localparam logic [10:0] LANE_DISPLACE    = 11'h400;
  localparam logic [10:0] CTRL_WORD        = SINGLE_CTRL_WORD + LANE_DISPLACE;
  localparam logic [10:0] PHY_WIN_FIRST    = 11'h4b0;
  localparam logic [10:0] PHY_WIN_LAST     = 11'h4ff;

  // Field positions of the control word.
  localparam int unsigned BIT_RESTART   = 0;
  localparam int unsigned BIT_AN_TMR    = 1;
  localparam int unsigned BIT_LF_TMR    = 2;
  localparam int unsigned BIT_ERR_FAIL  = 3;
  localparam int unsigned OVR_LSB       = 4;
  localparam int unsigned OVR_MSB       = 7;
  localparam int unsigned BIT_CALIB     = 8;
  localparam int unsigned RSV_LSB       = 9;
  localparam int unsigned RSV_MSB       = 11;
  localparam int unsigned BIT_FAIL_ACT  = 12;
  localparam int unsigned STORED_MSB    = 12;

  localparam logic [12:0] CTRL_RESET    = 13'h0000;
  localparam logic [3:0]  OVR_RESET     = 4'h0;
  localparam logic [31:0] READ_ZERO     = 32'h0000_0000;

  // Protocol override codes.
  localparam logic [3:0] MODE_NONE   = 4'h0;
  localparam logic [3:0] MODE_GIGE   = 4'h1;
  localparam logic [3:0] MODE_QUAD   = 4'h2;
  localparam logic [3:0] MODE_10G    = 4'h4;
  localparam logic [3:0] MODE_KR     = 4'h5;
  localparam logic [3:0] MODE_KR_FEC = 4'hc;

endpackage

// File: verilog/krsc_restart_pulse.sv
/*
  Turns a write of one into the restart bit into a single registered pulse and captures the protocol
  override presented with it.
  Assumes the write strobe is synchronous to sys_clk and at most one cycle wide per write.
*/
module krsc_restart_pulse (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // Write side
  input  wire logic       restartWrite,
  input  wire logic [3:0] overrideIn,
  // Sequencer side
  output logic            restartPulse_q,
  output logic [3:0]      activeOverride_q
);

  logic       restartPulse_d;
  logic [3:0] activeOverride_d;

  // The pulse is held for one cycle only, so the stored bit never needs software to clear it.
  assign restartPulse_d   = restartWrite; // R2
  // The override only moves when a restart is written, never on a plain field write.
  assign activeOverride_d = restartWrite ? overrideIn : activeOverride_q; // R8

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      restartPulse_q   <= 1'b0;
      activeOverride_q <= krsc_pkg::OVR_RESET;
    end else begin
      restartPulse_q   <= restartPulse_d;
      activeOverride_q <= activeOverride_d;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_pulse_single_cycle: assert property (restartPulse_q && !restartWrite |=> !restartPulse_q) // R2
    else $error("restart pulse stretched without a new write");
  a_pulse_needs_write: assert property (restartPulse_q |-> $past(restartWrite)) // R1
    else $error("restart pulse without a restart write");
  a_override_holds: assert property (!restartWrite |=> $stable(activeOverride_q)) // R8
    else $error("active override changed without a restart");

endmodule

// File: sim/kr_sequencer_control_tb_top.sv
/*
  Self-checking bench for the sequencer control register: register access, restart walk, override codes,
  timer enables and training failure handling.
  Assumes the register port answers a read one cycle after the strobe and never stalls.
*/
`define CHK(got, exp) begin checksDone++; if ((got) !== (exp)) begin failCount++; \
  $display("unexpected at %0t: got %0h exp %0h", $time, got, exp); end end
module kr_sequencer_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic        sysClk;
  logic        rstN;
  logic [10:0] mgmtAddr;
  logic        mgmtRead;
  logic        mgmtWrite;
  logic [31:0] mgmtWriteData;
  logic [31:0] mgmtReadData;
  logic        mgmtReadValid;
  logic        negotiationEnabled;
  logic        trainingEnabled;
  logic        trainingFailIn;
  logic        trainingRunDone;
  logic [7:0]  trainingLastError;
  logic        seqRestart;
  logic        reconfigStart;
  logic        reconfigCalibrate;
  logic [3:0]  activeProtocol;
  logic        negotiationTimerOn;
  logic        linkFailTimerOn;
  logic        negotiationRestart;
  logic        trainingRestart;
  logic        enterDataMode;
  int          failCount;
  int          checksDone;
  logic [3:0]  codes [6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'hc};
  logic [31:0] rdData;
  logic [31:0] wData;

  krsc_control dut_u (
    .sys_clk(sysClk), .rst_n(rstN), .mgmtAddr(mgmtAddr), .mgmtRead(mgmtRead), .mgmtWrite(mgmtWrite),
    .mgmtWriteData(mgmtWriteData), .mgmtReadData(mgmtReadData), .mgmtReadValid(mgmtReadValid),
    .negotiationEnabled(negotiationEnabled), .trainingEnabled(trainingEnabled),
    .trainingFailIn(trainingFailIn), .trainingRunDone(trainingRunDone), .trainingLastError(trainingLastError),
    .seqRestart(seqRestart), .reconfigStart(reconfigStart), .reconfigCalibrate(reconfigCalibrate),
    .activeProtocol(activeProtocol), .negotiationTimerOn(negotiationTimerOn), .linkFailTimerOn(linkFailTimerOn),
    .negotiationRestart(negotiationRestart), .trainingRestart(trainingRestart), .enterDataMode(enterDataMode)
  );

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    sysClk = 1'b0;
    forever #10 sysClk = ~sysClk;
  end

  task automatic stopTest();
    if (failCount == 0 && checksDone > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Each access ends on a falling edge, so registered answers are already settled there.
  task automatic wr(input logic [10:0] a, input logic [31:0] d);
    @(negedge sysClk);
    mgmtAddr = a;
    mgmtWriteData = d;
    mgmtWrite = 1'b1;
    @(posedge sysClk);
    @(negedge sysClk);
    mgmtWrite = 1'b0;
  endtask

  task automatic rd(input logic [10:0] a, output logic [31:0] d);
    @(negedge sysClk);
    mgmtAddr = a;
    mgmtRead = 1'b1;
    @(posedge sysClk);
    @(negedge sysClk);
    mgmtRead = 1'b0;
    `CHK(mgmtReadValid, 1'b1)
    d = mgmtReadData;
  endtask

  task automatic ev(input logic fail, input logic done, input logic [7:0] err);
    @(negedge sysClk);
    trainingFailIn = fail;
    trainingRunDone = done;
    trainingLastError = err;
    @(posedge sysClk);
    @(negedge sysClk);
    trainingFailIn = 1'b0;
    trainingRunDone = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    failCount = 0;
    checksDone = 0;
    rstN = 1'b0;
    {mgmtAddr, mgmtRead, mgmtWrite, mgmtWriteData} = '0;
    {negotiationEnabled, trainingEnabled, trainingFailIn, trainingRunDone, trainingLastError} = '0;
    repeat (5) @(posedge sysClk);
    @(negedge sysClk);
    rstN = 1'b1;
    rd(11'h4b0, rdData);
    `CHK(rdData, 32'h0000_0000)
    `CHK({negotiationTimerOn, linkFailTimerOn, activeProtocol}, 6'h30)
    // Every field but restart set, override staged without a restart, FEC bits written but not stored.
    wr(11'h4b0, 32'hffff_ff5e);
    `CHK(seqRestart, 1'b0)
    rd(11'h4b0, rdData);
    `CHK(rdData, 32'h0000_1f5e)
    `CHK(negotiationTimerOn, 1'b0)
    `CHK(linkFailTimerOn, 1'b0)
    `CHK(activeProtocol, 4'h0)
    negotiationEnabled = 1'b1;
    ev(1'b1, 1'b0, 8'h00);
    `CHK({enterDataMode, negotiationRestart, trainingRestart}, 3'b100)
    wr(11'h4b0, 32'h0000_0008);
    `CHK({negotiationTimerOn, linkFailTimerOn}, 2'b11)
    ev(1'b0, 1'b1, 8'h00);
    `CHK({enterDataMode, negotiationRestart, trainingRestart}, 3'b000)
    ev(1'b0, 1'b1, 8'h01);
    `CHK({enterDataMode, negotiationRestart, trainingRestart}, 3'b010)
    negotiationEnabled = 1'b0;
    ev(1'b1, 1'b0, 8'h00);
    `CHK({enterDataMode, negotiationRestart, trainingRestart}, 3'b001)
    wr(11'h4b0, 32'h0000_0000);
    ev(1'b0, 1'b1, 8'hff);
    `CHK({enterDataMode, negotiationRestart, trainingRestart}, 3'b000)
    wr(11'h4b0, 32'h0000_1008);
    ev(1'b0, 1'b1, 8'h01);
    `CHK({enterDataMode, negotiationRestart, trainingRestart}, 3'b100)
    // The single-lane offset is not this register in the four-lane map; it is read only, never written.
    rd(11'h0b0, rdData);
    `CHK(rdData, 32'h0000_0000)
    rd(11'h4b0, rdData);
    `CHK(rdData, 32'h0000_1008)
    for (int i = 0; i < 6; i++) begin
      negotiationEnabled = i[0];
      trainingEnabled = i[1];
      wData = {19'h0, 4'h0, i[0], codes[i], 4'h1};
      wr(11'h4b0, wData);
      `CHK(seqRestart, 1'b1)
      `CHK(activeProtocol, codes[i])
      @(negedge sysClk);
      `CHK({seqRestart, reconfigStart, reconfigCalibrate}, {2'b01, i[0]})
      `CHK({negotiationRestart, trainingRestart}, {i[0], i[1]})
      @(negedge sysClk);
      `CHK({reconfigStart, negotiationRestart, trainingRestart}, 3'b000)
      rd(11'h4b0, rdData);
      `CHK(rdData, wData & 32'h0000_1ffe)
    end
    stopTest();
  end

  initial begin
    #400000;
    failCount++;
    stopTest();
  end
endmodule
